/* File: common/rst_init_pkg.sv */
package rst_init_pkg;
   localparam int PC_W = 13;
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam int STACK_DEPTH = 8;
   // Status field positions
   localparam int ST_TOP_LO = 5;
   localparam int ST_TIMEOUT_BIT = 4;
   localparam int ST_PWRDN_BIT = 3;
   localparam logic [4:0] ST_SLEEP_RST_PAT = 5'h02;
   // Power-control field positions
   localparam int PC_TOP_BIT = 3;
   localparam int PC_BROWNOUT_BIT = 0;
   localparam int IRQ_FLAG_W = 8;
   typedef enum logic [2:0] {
      CAUSE_NONE,
      CAUSE_PIN_RUN,
      CAUSE_PIN_SLEEP,
      CAUSE_WDOG_RESET,
      CAUSE_BROWNOUT,
      CAUSE_WAKE_RESET,
      CAUSE_IRQ_WAKE
   } cause_t;
endpackage : rst_init_pkg

/* File: rtl/irq_vector_stack.sv */
`timescale 1ns/1ps
module irq_vector_stack
   import rst_init_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic push,
   input wire logic pop,
   input wire logic [12:0] push_addr,
   output logic [12:0] top_addr
);
   typedef struct packed {
      logic [DEPTH-1:0][12:0] mem;
      logic [$clog2(DEPTH)-1:0] ptr;
   } stack_state_t;
   stack_state_t state, next_state;
   localparam logic [$clog2(DEPTH)-1:0] ONE = 1;

   always_comb begin
      next_state = state;
      // Wraps like a circular return stack; overflow overwrites the oldest
      if (push) begin
         next_state.mem[state.ptr] = push_addr;
         next_state.ptr = state.ptr + ONE;
      end else if (pop) begin
         next_state.ptr = state.ptr - ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign top_addr = state.mem[state.ptr - ONE];
endmodule : irq_vector_stack

/* File: rtl/reset_state_initializer.sv */
`timescale 1ns/1ps
// How it works
// - Every true reset sends the program counter to address 0.
// - A pin reset while running clears status bits 7..5 and power bit 3.
// - A pin reset while asleep loads status 7..3 with 00010, clears power bit 3.
// - An interrupt wake resumes at PC+1, sets status bit 4, clears bit 3.
// - With interrupts enabled that wake runs PC+1, then jumps to the vector.
// - Brown-out clears power bit 0; other causes leave it unchanged.
// - An interrupt wake sets the waking flags in the irq flag registers.
// - Servicing clears the global enable, pushes return address, loads 0004.
module reset_state_initializer
   import rst_init_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic EXTERNAL_RESET_PIN_N,
   input wire logic WATCHDOG_TIMER_RESET,
   input wire logic WATCHDOG_TIMER_WAKE,
   input wire logic BROWNOUT,
   input wire logic WAKE_RESET,
   input wire logic IRQ_WAKE,
   input wire logic [IRQ_FLAG_W-1:0] CORE_IRQ_WAKE_BITS,
   input wire logic [IRQ_FLAG_W-1:0] PERIPH_IRQ_WAKE_BITS,
   input wire logic ASLEEP,
   input wire logic GLOBAL_IRQ_ENABLE_IN,
   input wire logic IRQ_SERVICE,
   input wire logic IRQ_RETURN,
   input wire logic PC_STEP,
   input wire logic [7:0] STATUS_IN,
   input wire logic [3:0] POWER_CONTROL_IN,
   input wire logic [IRQ_FLAG_W-1:0] CORE_IRQ_CONTROL_IN,
   input wire logic [IRQ_FLAG_W-1:0] PERIPH_IRQ_FLAG_IN,
   output logic [12:0] PROGRAM_COUNTER,
   output logic [7:0] STATUS_OUT,
   output logic [3:0] POWER_CONTROL_OUT,
   output logic [IRQ_FLAG_W-1:0] CORE_IRQ_CONTROL_REG,
   output logic [IRQ_FLAG_W-1:0] PERIPH_IRQ_FLAG_REG,
   output logic GLOBAL_IRQ_ENABLE,
   output logic LOAD_STROBE,
   output logic HOLD
);
   typedef struct packed {
      logic [1:0] pin_sync;
      logic [1:0] wdr_sync;
      logic [1:0] bor_sync;
      logic [1:0] wkr_sync;
      // Third stage only feeds the edge detector for the watchdog wake
      logic [2:0] wdw_sync;
      cause_t cause;
      logic vector_pending;
      logic [12:0] pc;
      logic [7:0] status;
      logic [3:0] power_control_reg;
      logic [IRQ_FLAG_W-1:0] core_flags;
      logic [IRQ_FLAG_W-1:0] periph_flags;
      logic global_irq_enable;
      logic load;
   } init_state_t;

   init_state_t state, next_state;
   logic pin_rst, wdog_rst, bor_rst, wake_rst, any_rst;
   logic push, pop;
   logic [12:0] ret_addr;
   logic wdog_wake, idle, vec_go, svc_go, ret_go;

   assign pin_rst = state.pin_sync[1];
   assign wdog_rst = state.wdr_sync[1];
   assign bor_rst = state.bor_sync[1];
   assign wake_rst = state.wkr_sync[1];
   assign any_rst = pin_rst | wdog_rst | bor_rst | wake_rst;
   // Watchdog wake is a level; only its rising edge wakes the core once
   assign wdog_wake = state.wdw_sync[1] & ~state.wdw_sync[2];

   // These mirror the priority chain below, so the stack moves only when
   // the matching program counter load really happens
   assign idle = ~any_rst
      & (state.cause == CAUSE_NONE)
      & ~(IRQ_WAKE & ASLEEP)
      & ~(wdog_wake & ASLEEP);
   assign vec_go = idle & state.vector_pending & PC_STEP;
   assign svc_go = idle & ~vec_go & IRQ_SERVICE & GLOBAL_IRQ_ENABLE_IN;
   assign ret_go = idle
      & ~vec_go
      & ~(IRQ_SERVICE & GLOBAL_IRQ_ENABLE_IN)
      & IRQ_RETURN;
   // Both vectoring paths save the address they leave from
   assign push = vec_go | svc_go;
   assign pop = ret_go;

   irq_vector_stack #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .clk(REF_CLK),
      .nrst(NRST),
      .push(push),
      .pop(pop),
      .push_addr(state.pc),
      .top_addr(ret_addr)
   );

   always_comb begin
      next_state = state;
      next_state.load = 1'b0;
      next_state.pin_sync = {state.pin_sync[0], ~EXTERNAL_RESET_PIN_N};
      next_state.wdr_sync = {state.wdr_sync[0], WATCHDOG_TIMER_RESET};
      next_state.bor_sync = {state.bor_sync[0], BROWNOUT};
      next_state.wkr_sync = {state.wkr_sync[0], WAKE_RESET};
      next_state.wdw_sync = {state.wdw_sync[1:0], WATCHDOG_TIMER_WAKE};
      if (!any_rst && state.cause == CAUSE_NONE) begin
         next_state.status = STATUS_IN;
         next_state.power_control_reg = POWER_CONTROL_IN;
         next_state.core_flags = CORE_IRQ_CONTROL_IN;
         next_state.periph_flags = PERIPH_IRQ_FLAG_IN;
         next_state.global_irq_enable = GLOBAL_IRQ_ENABLE_IN;
      end
      if (any_rst) begin
         // Brown-out outranks the others since its power bit effect is unique
         if (bor_rst) begin
            next_state.cause = CAUSE_BROWNOUT;
         end else if (wake_rst) begin
            next_state.cause = CAUSE_WAKE_RESET;
         end else if (wdog_rst) begin
            next_state.cause = CAUSE_WDOG_RESET;
         end else if (ASLEEP) begin
            next_state.cause = CAUSE_PIN_SLEEP;
         end else begin
            next_state.cause = CAUSE_PIN_RUN;
         end
         next_state.vector_pending = 1'b0;
      end else if (state.cause != CAUSE_NONE) begin
         // Condition has ended: apply the recorded initialization now
         next_state.load = 1'b1;
         next_state.cause = CAUSE_NONE;
         next_state.pc = RESET_VECTOR;
         next_state.global_irq_enable = 1'b0;
         unique case (state.cause)
            CAUSE_PIN_RUN: begin
               next_state.status[7:ST_TOP_LO] = 3'h0;
               next_state.power_control_reg[PC_TOP_BIT] = 1'b0;
            end
            CAUSE_PIN_SLEEP: begin
               next_state.status[7:ST_PWRDN_BIT] = ST_SLEEP_RST_PAT;
               next_state.power_control_reg[PC_TOP_BIT] = 1'b0;
            end
            CAUSE_WDOG_RESET, CAUSE_WAKE_RESET: begin
               next_state.power_control_reg[PC_TOP_BIT] = 1'b0;
            end
            CAUSE_BROWNOUT: begin
               next_state.power_control_reg[PC_TOP_BIT] = 1'b0;
               next_state.power_control_reg[PC_BROWNOUT_BIT] = 1'b0;
            end
            default: begin
            end
         endcase
      end else if (IRQ_WAKE && ASLEEP) begin
         next_state.load = 1'b1;
         next_state.pc = state.pc + 13'h0001;
         next_state.status[ST_TIMEOUT_BIT] = 1'b1;
         next_state.status[ST_PWRDN_BIT] = 1'b0;
         next_state.core_flags = CORE_IRQ_CONTROL_IN | CORE_IRQ_WAKE_BITS;
         next_state.periph_flags = PERIPH_IRQ_FLAG_IN
            | PERIPH_IRQ_WAKE_BITS;
         // Vector only after the PC+1 instruction has run
         next_state.vector_pending = GLOBAL_IRQ_ENABLE_IN;
      end else if (wdog_wake && ASLEEP) begin
         // Watchdog wake resumes at PC+1 and clears both sleep flags
         next_state.load = 1'b1;
         next_state.pc = state.pc + 13'h0001;
         next_state.status[ST_TIMEOUT_BIT] = 1'b0;
         next_state.status[ST_PWRDN_BIT] = 1'b0;
      end else if (state.vector_pending && PC_STEP) begin
         next_state.vector_pending = 1'b0;
         next_state.pc = IRQ_VECTOR;
         next_state.global_irq_enable = 1'b0;
         next_state.load = 1'b1;
      end else if (IRQ_SERVICE && GLOBAL_IRQ_ENABLE_IN) begin
         next_state.pc = IRQ_VECTOR;
         next_state.global_irq_enable = 1'b0;
         next_state.load = 1'b1;
      end else if (IRQ_RETURN) begin
         next_state.pc = ret_addr;
         next_state.global_irq_enable = 1'b1;
         next_state.load = 1'b1;
      end else if (PC_STEP) begin
         next_state.pc = state.pc + 13'h0001;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         state <= '0;
         state.cause <= CAUSE_WAKE_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign PROGRAM_COUNTER = state.pc;
   assign STATUS_OUT = state.status;
   assign POWER_CONTROL_OUT = state.power_control_reg;
   assign CORE_IRQ_CONTROL_REG = state.core_flags;
   assign PERIPH_IRQ_FLAG_REG = state.periph_flags;
   assign GLOBAL_IRQ_ENABLE = state.global_irq_enable;
   assign LOAD_STROBE = state.load;
   assign HOLD = any_rst | (state.cause != CAUSE_NONE);
endmodule : reset_state_initializer

/* File: testbench/reset_state_initializer_checker.sv */
`timescale 1ns/1ps
module reset_state_initializer_checker
   import rst_init_pkg::*;
(
   input wire logic REF_CLK, NRST, EXTERNAL_RESET_PIN_N, BROWNOUT,
   input wire logic WATCHDOG_TIMER_RESET, IRQ_WAKE, ASLEEP, PC_STEP,
   input wire logic GLOBAL_IRQ_ENABLE_IN, GLOBAL_IRQ_ENABLE,
   input wire logic LOAD_STROBE, HOLD,
   input wire logic [IRQ_FLAG_W-1:0] CORE_IRQ_WAKE_BITS,
   input wire logic [IRQ_FLAG_W-1:0] CORE_IRQ_CONTROL_REG,
   input wire logic [12:0] PROGRAM_COUNTER,
   input wire logic [7:0] STATUS_OUT,
   input wire logic [3:0] POWER_CONTROL_OUT, POWER_CONTROL_IN
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   wire logic at0 = LOAD_STROBE && PROGRAM_COUNTER == RESET_VECTOR;
   sequence wake_s;
      IRQ_WAKE && ASLEEP && !HOLD;
   endsequence
   sequence wake_gie_s;
      IRQ_WAKE && ASLEEP && !HOLD && GLOBAL_IRQ_ENABLE_IN;
   endsequence
   // Windows allow for the two-stage input synchroniser
   reset_init_a:
   assert property ($rose(NRST) |-> ##[1:2] at0) else $error("no init");
   pin_run_a:
   assert property ($rose(EXTERNAL_RESET_PIN_N) && !ASLEEP |-> ##[1:6]
      at0 && STATUS_OUT[7:5] == 3'h0 && !POWER_CONTROL_OUT[3]
      && POWER_CONTROL_OUT[0] == POWER_CONTROL_IN[0])
      else $error("pin reset while running");
   pin_sleep_a:
   assert property ($rose(EXTERNAL_RESET_PIN_N) && ASLEEP |-> ##[1:6]
      at0 && STATUS_OUT[7:3] == 5'h02 && !POWER_CONTROL_OUT[3])
      else $error("pin reset while asleep");
   wdog_reset_a:
   assert property ($fell(WATCHDOG_TIMER_RESET) |-> ##[1:6] at0)
      else $error("watchdog reset");
   brownout_clear_a:
   assert property ($fell(BROWNOUT) |-> ##[1:6] at0
      && POWER_CONTROL_OUT[0] == 1'b0) else $error("brownout");
   wake_status_a:
   assert property (wake_s |=> LOAD_STROBE && STATUS_OUT[4:3] == 2'h2
      && PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 13'h1
      && POWER_CONTROL_OUT == $past(POWER_CONTROL_OUT))
      else $error("irq wake state");
   wake_flags_a:
   assert property (wake_s |=> (CORE_IRQ_CONTROL_REG
      & $past(CORE_IRQ_WAKE_BITS)) == $past(CORE_IRQ_WAKE_BITS))
      else $error("wake flags not set");
   wake_vector_a:
   assert property (wake_gie_s ##2 PC_STEP |=> LOAD_STROBE
      && PROGRAM_COUNTER == IRQ_VECTOR && !GLOBAL_IRQ_ENABLE)
      else $error("no vector after wake");
endmodule : reset_state_initializer_checker

bind reset_state_initializer reset_state_initializer_checker
   reset_state_initializer_checker_inst (.*);

/* File: testbench/reset_state_initializer_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_tests++; if ((e) !== (a)) begin \
   err_total++; $display("ERROR %s expected %h seen %h", nm, e, a); end end
module reset_state_initializer_tb
   import rst_init_pkg::*;
;
   logic REF_CLK = 0, NRST = 0, EXTERNAL_RESET_PIN_N = 1, BROWNOUT = 0;
   logic WATCHDOG_TIMER_RESET = 0, WATCHDOG_TIMER_WAKE = 0, WAKE_RESET = 0;
   logic IRQ_WAKE = 0, ASLEEP = 0, GLOBAL_IRQ_ENABLE_IN = 0, PC_STEP = 0;
   logic IRQ_SERVICE = 0, IRQ_RETURN = 0, GLOBAL_IRQ_ENABLE, LOAD_STROBE;
   logic HOLD;
   logic [7:0] STATUS_IN = 0, CORE_IRQ_WAKE_BITS = 0;
   logic [7:0] PERIPH_IRQ_WAKE_BITS = 0, CORE_IRQ_CONTROL_IN = 0;
   logic [7:0] PERIPH_IRQ_FLAG_IN = 0, STATUS_OUT, CORE_IRQ_CONTROL_REG;
   logic [7:0] PERIPH_IRQ_FLAG_REG;
   logic [3:0] POWER_CONTROL_IN = 0, POWER_CONTROL_OUT;
   logic [12:0] PROGRAM_COUNTER, pc;
   logic [28:0] n;
   logic [28:0] notes[$];
   int err_total = 0, n_tests = 0, seed = 65, k;
   reset_state_initializer reset_state_initializer_inst (.*);
   initial forever #20 REF_CLK = ~REF_CLK;
   task automatic tick(int c);
      repeat (c) @(negedge REF_CLK);
   endtask : tick
   // Note layout: status mask, status value, program counter
   task automatic note(logic [7:0] m, v, logic [12:0] p);
      notes.push_back({m, v, p});
   endtask : note
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic drain(string nm);
      for (int i = 0; i < 30 && notes.size() > 0; i++) tick(1);
      if (notes.size() > 0) begin
         err_total++;
         $display("ERROR %s expected strobe seen none", nm);
         report_and_stop();
      end
      tick(3);
      $display("test %s done", nm);
   endtask : drain
   always @(negedge REF_CLK) begin
      if (NRST && LOAD_STROBE === 1'b1) begin
         `CHK("note", 1'b1, notes.size() > 0)
         if (notes.size() > 0) n = notes.pop_front();
         `CHK("pc", n[12:0], PROGRAM_COUNTER)
         `CHK("status", n[20:13], STATUS_OUT & n[28:21])
      end
   end
   initial begin
      tick(12);
      note(8'h00, 8'h00, RESET_VECTOR);
      NRST = 1;
      drain("reset");
      STATUS_IN = $random(seed);
      POWER_CONTROL_IN = $random(seed);
      CORE_IRQ_CONTROL_IN = $random(seed);
      PERIPH_IRQ_FLAG_IN = $random(seed);
      for (int s = 0; s < 2; s++) begin
         ASLEEP = s[0];
         EXTERNAL_RESET_PIN_N = 0;
         tick(3);
         `CHK("hold", 1'b1, HOLD)
         note(s ? 8'hf8 : 8'he0, s ? 8'h10 : 8'h00, RESET_VECTOR);
         EXTERNAL_RESET_PIN_N = 1;
         drain("pin reset");
         ASLEEP = 0;
         if (s) BROWNOUT = 1;
         else WATCHDOG_TIMER_RESET = 1;
         tick(3);
         note(8'h00, 8'h00, RESET_VECTOR);
         BROWNOUT = 0;
         WATCHDOG_TIMER_RESET = 0;
         drain("source reset");
      end
      pc = RESET_VECTOR;
      for (int i = 0; i < 3; i++) begin
         k = 1 + ($random(seed) & 3);
         PC_STEP = 1;
         tick(k);
         PC_STEP = 0;
         pc = pc + 13'(k);
         ASLEEP = 1;
         GLOBAL_IRQ_ENABLE_IN = i[0];
         CORE_IRQ_WAKE_BITS = $random(seed);
         PERIPH_IRQ_WAKE_BITS = $random(seed);
         tick(1);
         note(8'h18, 8'h10, pc + 13'h1);
         IRQ_WAKE = 1;
         tick(1);
         `CHK("core", CORE_IRQ_CONTROL_IN | CORE_IRQ_WAKE_BITS,
            CORE_IRQ_CONTROL_REG)
         `CHK("periph", PERIPH_IRQ_FLAG_IN | PERIPH_IRQ_WAKE_BITS,
            PERIPH_IRQ_FLAG_REG)
         IRQ_WAKE = 0;
         ASLEEP = 0;
         pc = pc + 13'h1;
         if (i[0]) begin
            tick(1);
            PC_STEP = 1;
            note(8'h00, 8'h00, IRQ_VECTOR);
            tick(1);
            PC_STEP = 0;
            pc = IRQ_VECTOR;
         end
         drain("irq wake");
      end
      ASLEEP = 1;
      note(8'h18, 8'h00, pc + 13'h1);
      WATCHDOG_TIMER_WAKE = 1;
      tick(5);
      WATCHDOG_TIMER_WAKE = 0;
      ASLEEP = 0;
      pc = pc + 13'h1;
      drain("watchdog wake");
      GLOBAL_IRQ_ENABLE_IN = 1;
      note(8'h00, 8'h00, IRQ_VECTOR);
      IRQ_SERVICE = 1;
      tick(1);
      IRQ_SERVICE = 0;
      GLOBAL_IRQ_ENABLE_IN = 0;
      `CHK("gie", 1'b0, GLOBAL_IRQ_ENABLE)
      note(8'h00, 8'h00, pc);
      IRQ_RETURN = 1;
      tick(1);
      IRQ_RETURN = 0;
      `CHK("gie", 1'b1, GLOBAL_IRQ_ENABLE)
      drain("service return");
      report_and_stop();
   end
endmodule : reset_state_initializer_tb
